// ===== rtl/cfg_seq_pkg.sv
// Constants and carrier types for the configuration sequencer.
package cfg_seq_pkg;

  // Program request low time, in ns, and its count of 20 ns cycles, rounded up.
  localparam int unsigned CLK_PERIOD_NS       = 20;
  localparam int unsigned PROGRAM_LOW_MIN_NS  = 300;
  localparam int unsigned PROGRAM_LOW_CYCLES  = (PROGRAM_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Cycles spent clearing configuration memory.
  localparam int unsigned CLEAR_CYCLES_DEF    = 64;

  // Start-up phase defaults: done pin in phase 4, output float in 5, write enable in 6.
  localparam logic [2:0] DONE_PHASE_DEF       = 3'h4;
  localparam logic [2:0] FLOAT_PHASE_DEF      = 3'h5;
  localparam logic [2:0] WRITE_PHASE_DEF      = 3'h6;
  localparam logic [2:0] PHASE_MIN            = 3'h1;
  localparam logic [2:0] PHASE_MAX            = 3'h6;
  localparam logic [2:0] PHASE_LAST           = 3'h7;

  // Start-up clock source select.
  localparam logic [1:0] STARTUP_CLK_CONFIG   = 2'h0;
  localparam logic [1:0] STARTUP_CLK_APP      = 2'h1;
  localparam logic [1:0] STARTUP_CLK_JTAG     = 2'h2;

  // Security levels: 0 none, 1 and 2 block readback.
  localparam logic [1:0] SECURITY_NONE        = 2'h0;

  // Readback port select.
  localparam logic [1:0] READBACK_PORT_NONE     = 2'h0;
  localparam logic [1:0] READBACK_PORT_PARALLEL = 2'h1;
  localparam logic [1:0] READBACK_PORT_JTAG     = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_PROGRAM = 6'h02,
    ST_CLEAR   = 6'h04,
    ST_WAIT    = 6'h08,
    ST_LOAD    = 6'h10,
    ST_STARTUP = 6'h20
  } seq_state_type;

  typedef struct packed {
    logic [1:0] startup_clock_select;
    logic [2:0] done_phase;
    logic [2:0] float_phase;
    logic [2:0] write_phase;
    logic       float_wait_done;
    logic       write_wait_done;
    logic       lock_wait_en;
    logic [2:0] lock_phase;
    logic [1:0] security_level;
  } startup_cfg_type;

  typedef struct packed {
    logic       global_set_reset;
    logic       global_output_float;
    logic       global_write_enable;
    logic       user_io_mode;
  } global_ctrl_type;

endpackage

// ===== rtl/startup_phase_ctrl.sv
// Start-up phase counter that steps once per selected start-up clock edge while not held, and stops at phase 7.
`timescale 1ns/10ps
module startup_phase_ctrl (
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        run_i,
  input  wire logic                        step_i,
  input  wire logic                        hold_i,
  output logic [2:0]                       phase_o
);

  logic [2:0] phase_q;
  logic [2:0] phase_d;
  wire        advance = run_i && step_i && !hold_i && (phase_q != cfg_seq_pkg::PHASE_LAST);

  assign phase_d = !run_i ? 3'h0 : (advance ? phase_q + 3'h1 : phase_q);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase_q <= 3'h0;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase_o = phase_q;

  phase_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    advance |=> phase_q == $past(phase_q) + 3'h1) else $error("Start-up phase did not step by one.");
  phase_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    run_i && $past(run_i) && !(step_i && !hold_i) |=> $stable(phase_q))
    else $error("Start-up phase moved without a step.");

endmodule

// ===== rtl/config_sequence_startup_ctrl.sv
// Configuration sequencer and start-up controller of a programmable logic device.
`timescale 1ns/10ps
// Summary of operation
// - Configuration starts on power-on reset and on a program request.
// - Stages run in order: clear memory, load data, start-up.
// - Init status pin is driven low while memory is cleared.
// - External low on init status pin stalls the sequencer until high.
// - Init status pin is released when clearing finishes.
// - Global set/reset is held throughout data loading.
// - Done pin is released once configuration completes.
// - Releasing program request starts clearing and the later stages.
// - Global set/reset pulses at the end of configuration.
// - With the default phases, output float releases one start-up cycle after done goes high.
// - With the default phases, write enable releases one start-up cycle after output float.
// - Dual-purpose configuration pins become user I/O once done is high.
// - Dual-purpose pins stay undriven until output float is released.
// - Optionally float and write releases wait for the shared done line.
// - Optionally start-up pauses at a phase until clock managers lock.
// - By default start-up steps on the configuration clock.
// - Optionally start-up steps on the application clock.
// - Application may assert global set/reset and output float later.
// - Under JTAG configuration start-up may step on the test clock.
// - Readback only through slave parallel or JTAG port.
// - Readback is disabled at either protection level.
// - Readback includes registers; capture timed by the application.
// - A CRC error drives the init status pin low.
// - Done phase is selectable from one to six.
module config_sequence_startup_ctrl #(
  parameter int unsigned CLEAR_CYCLES = cfg_seq_pkg::CLEAR_CYCLES_DEF,
  parameter int unsigned LOCK_WIDTH   = 4
) (
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        program_request_n_i,
  input  wire logic                        init_status_i,
  output logic                             init_status_o,
  output logic                             init_status_oe_o,
  input  wire logic                        done_i,
  output logic                             done_o,
  output logic                             done_oe_o,
  input  wire logic                        load_complete_i,
  input  wire logic                        crc_error_i,
  input  wire cfg_seq_pkg::startup_cfg_type startup_cfg_i,
  input  wire logic                        config_clock_edge_i,
  input  wire logic                        application_clock_edge_i,
  input  wire logic                        jtag_clock_edge_i,
  input  wire logic                        jtag_config_i,
  input  wire logic [LOCK_WIDTH-1:0]       clock_manager_locked_i,
  input  wire logic [LOCK_WIDTH-1:0]       clock_manager_wait_mask_i,
  input  wire logic                        app_set_reset_i,
  input  wire logic                        app_output_float_i,
  input  wire logic                        app_capture_i,
  input  wire logic [1:0]                  readback_port_i,
  input  wire logic                        readback_req_i,
  output cfg_seq_pkg::global_ctrl_type     global_ctrl_o,
  output logic                             config_active_o,
  output logic                             readback_enable_o,
  output logic                             capture_strobe_o
);

  cfg_seq_pkg::seq_state_type state_q;
  cfg_seq_pkg::seq_state_type state_d;
  logic [15:0] clear_cnt_q;
  logic        crc_fail_q;
  logic        gsr_q;
  logic        float_q;
  logic        write_q;
  logic        done_oe_q;
  logic        active_q;
  logic        io_mode_q;
  logic        readback_q;
  logic        capture_q;
  logic        init_drive_q;
  logic [2:0]  phase;

  wire step_sel = (startup_cfg_i.startup_clock_select == cfg_seq_pkg::STARTUP_CLK_APP)  ? application_clock_edge_i :
                  (startup_cfg_i.startup_clock_select == cfg_seq_pkg::STARTUP_CLK_JTAG && jtag_config_i)
                    ? jtag_clock_edge_i : config_clock_edge_i;

  wire locks_ok  = &(clock_manager_locked_i | ~clock_manager_wait_mask_i);
  wire lock_hold = startup_cfg_i.lock_wait_en && (phase == startup_cfg_i.lock_phase) && !locks_ok;

  // Shared phase test for the done, float and write releases.
  function automatic logic phase_reached(input logic [2:0] now_phase,
                                         input logic [2:0] target_phase);
    return now_phase >= target_phase;
  endfunction

  wire [2:0] done_ph = (startup_cfg_i.done_phase < cfg_seq_pkg::PHASE_MIN) ? cfg_seq_pkg::PHASE_MIN :
                       (startup_cfg_i.done_phase > cfg_seq_pkg::PHASE_MAX) ? cfg_seq_pkg::PHASE_MAX :
                       startup_cfg_i.done_phase;
  wire in_startup  = state_q == cfg_seq_pkg::ST_STARTUP;
  wire done_reach  = in_startup && phase_reached(phase, done_ph);
  wire float_reach = in_startup && phase_reached(phase, startup_cfg_i.float_phase) &&
                     (!startup_cfg_i.float_wait_done || done_i);
  wire write_reach = in_startup && phase_reached(phase, startup_cfg_i.write_phase) &&
                     (!startup_cfg_i.write_wait_done || done_i);
  wire clear_last  = clear_cnt_q == 16'(CLEAR_CYCLES - 1);

  startup_phase_ctrl u_phase (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (in_startup),
    .step_i    (step_sel),
    .hold_i    (lock_hold),
    .phase_o   (phase)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      cfg_seq_pkg::ST_IDLE: begin
        if (!program_request_n_i) begin
          state_d = cfg_seq_pkg::ST_PROGRAM;
        end
      end
      cfg_seq_pkg::ST_PROGRAM: begin
        if (program_request_n_i) begin
          state_d = cfg_seq_pkg::ST_CLEAR;
        end
      end
      cfg_seq_pkg::ST_CLEAR: begin
        if (clear_last) begin
          state_d = cfg_seq_pkg::ST_WAIT;
        end
      end
      cfg_seq_pkg::ST_WAIT: begin
        if (init_status_i) begin
          state_d = cfg_seq_pkg::ST_LOAD;
        end
      end
      cfg_seq_pkg::ST_LOAD: begin
        if (load_complete_i && !crc_error_i && !crc_fail_q) begin
          state_d = cfg_seq_pkg::ST_STARTUP;
        end
      end
      cfg_seq_pkg::ST_STARTUP: begin
        state_d = cfg_seq_pkg::ST_STARTUP;
      end
      default: state_d = cfg_seq_pkg::ST_PROGRAM;
    endcase
    // A program request aborts any stage and restarts configuration.
    if (!program_request_n_i) begin
      state_d = cfg_seq_pkg::ST_PROGRAM;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= cfg_seq_pkg::ST_PROGRAM;
    end else begin
      state_q <= state_d;
    end
  end

  // The clear counter is 16 bits wide, so CLEAR_CYCLES above 65536 is not supported.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_q != cfg_seq_pkg::ST_CLEAR) begin
      clear_cnt_q <= 16'h0000;
    end else begin
      clear_cnt_q <= clear_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_q == cfg_seq_pkg::ST_PROGRAM) begin
      crc_fail_q <= 1'b0;
    end else if (state_q == cfg_seq_pkg::ST_LOAD && crc_error_i) begin
      crc_fail_q <= 1'b1;
    end
  end

  // A CRC failure pulls the init pin low again, so the host learns that the load was refused.
  // clear drives low
  wire init_drive_d = (state_d == cfg_seq_pkg::ST_PROGRAM) || (state_d == cfg_seq_pkg::ST_CLEAR) ||
                      (state_d == cfg_seq_pkg::ST_LOAD && (crc_fail_q || crc_error_i));

  // application set reset
  // Set/reset stays up from power-on through loading, so the end pulse is its fall at the done phase.
  wire gsr_d   = !in_startup || !phase_reached(phase, done_ph) || app_set_reset_i;
  wire float_d = !float_reach || (in_startup && app_output_float_i);
  wire write_d = write_reach;
  wire done_rel_d = done_reach;
  wire io_mode_d  = done_reach && done_i;
  wire readback_d = readback_req_i && startup_cfg_i.security_level == cfg_seq_pkg::SECURITY_NONE &&
                    (readback_port_i == cfg_seq_pkg::READBACK_PORT_PARALLEL ||
                     readback_port_i == cfg_seq_pkg::READBACK_PORT_JTAG);
  wire capture_d  = app_capture_i && in_startup;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      init_drive_q <= 1'b1;
      gsr_q        <= 1'b1;
      float_q      <= 1'b1;
      write_q      <= 1'b0;
      done_oe_q    <= 1'b1;
      active_q     <= 1'b1;
      io_mode_q    <= 1'b0;
      readback_q   <= 1'b0;
      capture_q    <= 1'b0;
    end else begin
      init_drive_q <= init_drive_d;
      gsr_q        <= gsr_d;
      float_q      <= float_d;
      write_q      <= write_d;
      done_oe_q    <= !done_rel_d;
      active_q     <= !write_d;
      io_mode_q    <= io_mode_d;
      readback_q   <= readback_d;
      capture_q    <= capture_d;
    end
  end

  // Both open-drain data outputs are fixed low; only their enables move.
  assign init_status_o     = 1'b0;
  assign init_status_oe_o  = init_drive_q;
  assign done_o            = 1'b0;
  assign done_oe_o         = done_oe_q;
  assign global_ctrl_o     = '{global_set_reset:    gsr_q,
                               global_output_float: float_q,
                               global_write_enable: write_q,
                               user_io_mode:        io_mode_q};
  assign config_active_o   = active_q;
  assign readback_enable_o = readback_q;
  assign capture_strobe_o  = capture_q;

  power_on_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(sys_rst_i) |-> state_q == cfg_seq_pkg::ST_PROGRAM) else $error("Sequencer did not start after reset.");
  init_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == cfg_seq_pkg::ST_CLEAR |-> init_status_oe_o) else $error("Init pin not low in clear.");
  init_stall_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == cfg_seq_pkg::ST_WAIT && !init_status_i && program_request_n_i |=> state_q == cfg_seq_pkg::ST_WAIT)
    else $error("Sequencer left wait with init pin low.");
  init_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == cfg_seq_pkg::ST_CLEAR && clear_last && program_request_n_i |=> !init_status_oe_o)
    else $error("Init pin not released after clear.");
  gsr_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == cfg_seq_pkg::ST_LOAD |=> global_ctrl_o.global_set_reset) else $error("Set/reset dropped in load.");
  program_restart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == cfg_seq_pkg::ST_PROGRAM && program_request_n_i |=> state_q == cfg_seq_pkg::ST_CLEAR)
    else $error("No clear after program release.");
  // The float register follows the application request one cycle late, so that request is looked at one back.
  float_order_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    global_ctrl_o.global_write_enable && !startup_cfg_i.write_wait_done && !$past(app_output_float_i)
      && startup_cfg_i.write_phase > startup_cfg_i.float_phase && !startup_cfg_i.float_wait_done
      |-> !global_ctrl_o.global_output_float) else $error("Write enable before float release.");
  done_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    in_startup && phase >= done_ph && program_request_n_i |=> !done_oe_o) else $error("Done pin held low.");
  readback_secure_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    startup_cfg_i.security_level != cfg_seq_pkg::SECURITY_NONE |=> !readback_enable_o)
    else $error("Readback open under security.");
  io_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    global_ctrl_o.user_io_mode |-> !done_oe_o) else $error("User io mode before done.");
  gsr_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done_reach && !app_set_reset_i |=> !global_ctrl_o.global_set_reset)
    else $error("Set/reset held after the done phase.");
  float_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    in_startup && phase_reached(phase, startup_cfg_i.float_phase) && !startup_cfg_i.float_wait_done
      && !app_output_float_i |=> !global_ctrl_o.global_output_float) else $error("Output float not released.");
  load_order_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == cfg_seq_pkg::ST_LOAD
      |-> $past(state_q) == cfg_seq_pkg::ST_WAIT || $past(state_q) == cfg_seq_pkg::ST_LOAD)
    else $error("Load entered out of order.");
  crc_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == cfg_seq_pkg::ST_LOAD && crc_fail_q && program_request_n_i |=> init_status_oe_o)
    else $error("Init pin not low after CRC error.");
  step_source_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    in_startup && startup_cfg_i.startup_clock_select == cfg_seq_pkg::STARTUP_CLK_APP && !application_clock_edge_i
      |=> $stable(phase)) else $error("Start-up stepped without an application clock edge.");
  capture_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !in_startup |=> !capture_strobe_o) else $error("Capture strobe outside start-up.");

  startup_reach_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) global_ctrl_o.global_write_enable);
  init_stall_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == cfg_seq_pkg::ST_WAIT && !init_status_i);
  lock_hold_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) lock_hold);
  readback_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) readback_enable_o);
  crc_block_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) crc_fail_q);

endmodule

// ===== sim/cfg_board_model.sv
// Board model: pulled-up open-drain status wires and free-running start-up clock edges.
`timescale 1ns/10ps
module cfg_board_model (
  input  wire logic  clk_i,
  input  wire logic  sys_rst_i,
  input  wire logic  init_oe_i,
  input  wire logic  done_oe_i,
  input  wire logic  init_hold_i,
  input  wire logic  done_hold_i,
  output logic       init_wire_o,
  output logic       done_wire_o,
  output logic [2:0] edge_o
);
  logic [6:0] div_q;

  assign init_wire_o = ~(init_oe_i | init_hold_i);
  assign done_wire_o = ~(done_oe_i | done_hold_i);
  // Three unrelated rates, so a wrong clock source shows up as a wrong step count.
  assign edge_o = {div_q % 7'h07 == 7'h00, div_q % 7'h05 == 7'h00, div_q % 7'h04 == 7'h00};

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end
endmodule

// ===== sim/config_sequence_startup_ctrl_test.sv
// Self-checking bench for the configuration sequencer and start-up controller.
`timescale 1ns/10ps
module config_sequence_startup_ctrl_test;
  logic                         clk_i, sys_rst_i, prog_n, init_hold, done_hold, init_w, done_w;
  logic                         load_done, crc_err, jtag_cfg, app_sr, app_fl, app_cap, rb_req;
  logic                         init_oe, done_oe, active, rb_en, cap_st, init_lvl, done_lvl;
  logic [1:0]                   rb_port;
  logic [2:0]                   edge_v;
  logic [3:0]                   locked, mask;
  cfg_seq_pkg::startup_cfg_type cfg;
  cfg_seq_pkg::global_ctrl_type gc;
  int                           failures, comparisons, pulses, cycles, n;

  config_sequence_startup_ctrl #(.CLEAR_CYCLES(4), .LOCK_WIDTH(4)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .program_request_n_i(prog_n),
    .init_status_i(init_w), .init_status_o(init_lvl), .init_status_oe_o(init_oe),
    .done_i(done_w), .done_o(done_lvl), .done_oe_o(done_oe), .load_complete_i(load_done),
    .crc_error_i(crc_err), .startup_cfg_i(cfg), .config_clock_edge_i(edge_v[0]),
    .application_clock_edge_i(edge_v[1]), .jtag_clock_edge_i(edge_v[2]), .jtag_config_i(jtag_cfg),
    .clock_manager_locked_i(locked), .clock_manager_wait_mask_i(mask), .app_set_reset_i(app_sr),
    .app_output_float_i(app_fl), .app_capture_i(app_cap), .readback_port_i(rb_port),
    .readback_req_i(rb_req), .global_ctrl_o(gc), .config_active_o(active),
    .readback_enable_o(rb_en), .capture_strobe_o(cap_st));

  cfg_board_model board_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .init_oe_i(init_oe), .done_oe_i(done_oe),
    .init_hold_i(init_hold), .done_hold_i(done_hold), .init_wire_o(init_w),
    .done_wire_o(done_w), .edge_o(edge_v));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Step edges are counted on the selected source only.
  always @(posedge clk_i) begin
    cycles++;
    if (edge_v[cfg.startup_clock_select]) pulses++;
    if (cycles > 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  task automatic wait_done();
    for (n = 0; n < 600 && done_oe !== 1'b0; n++) cyc(1);
  endtask

  task automatic program_pulse();
    prog_n = 1'b0;
    cyc(16);
    chk({done_oe, init_oe, gc.global_output_float, gc.global_write_enable}, 4'hE);
    prog_n = 1'b1;
    cyc(2);
    chk({1'b0, init_oe, gc.global_set_reset, gc.user_io_mode}, 4'h6);
  endtask

  task automatic run_cfg(input logic [1:0] src, input logic [3:0] exp_fl, input logic [3:0] exp_wr);
    int t0;
    cfg.startup_clock_select = src;
    jtag_cfg = (src == cfg_seq_pkg::STARTUP_CLK_JTAG);
    program_pulse();
    wait_done();
    t0 = pulses;
    chk({2'h0, gc.global_set_reset, gc.global_output_float}, {3'h0, exp_fl != 4'h0});
    for (n = 0; n < 100 && gc.global_output_float !== 1'b0; n++) cyc(1);
    chk(4'(pulses - t0), exp_fl);
    t0 = pulses;
    for (n = 0; n < 100 && gc.global_write_enable !== 1'b1; n++) cyc(1);
    chk(4'(pulses - t0), exp_wr);
    cyc(1);
    chk({1'b0, done_w, gc.user_io_mode, active}, 4'h6);
  endtask

  initial begin
    int k;
    {prog_n, load_done, jtag_cfg, crc_err, app_sr, app_fl, app_cap, rb_req} = 8'hC0;
    {init_hold, done_hold, rb_port, locked, mask} = {2'h0, 2'h0, 4'hF, 4'hF};
    cfg = '0;
    cfg.done_phase = cfg_seq_pkg::DONE_PHASE_DEF;
    cfg.float_phase = cfg_seq_pkg::FLOAT_PHASE_DEF;
    cfg.write_phase = cfg_seq_pkg::WRITE_PHASE_DEF;
    cfg.lock_phase = 3'h2;
    sys_rst_i = 1'b1;
    cyc(8);
    chk({gc.global_set_reset, gc.global_output_float, gc.global_write_enable, init_oe}, 4'hD);
    chk({2'h0, init_lvl, done_lvl}, 4'h0);
    // Power-on start with the init wire held low by the board.
    init_hold = 1'b1;
    sys_rst_i = 1'b0;
    cyc(40);
    chk({init_oe, done_oe, gc.global_set_reset, done_w}, 4'h6);
    init_hold = 1'b0;
    wait_done();
    chk({3'h0, done_oe}, 4'h0);
    run_cfg(cfg_seq_pkg::STARTUP_CLK_CONFIG, 4'h1, 4'h1);
    run_cfg(cfg_seq_pkg::STARTUP_CLK_APP, 4'h1, 4'h1);
    run_cfg(cfg_seq_pkg::STARTUP_CLK_JTAG, 4'h1, 4'h1);
    for (k = 1; k <= 6; k++) begin
      cfg.done_phase = 3'(k);
      cfg.float_phase = cfg_seq_pkg::PHASE_MAX;
      cfg.write_phase = cfg_seq_pkg::PHASE_MAX;
      run_cfg(cfg_seq_pkg::STARTUP_CLK_CONFIG, 4'(6 - k), 4'h0);
    end
    cfg.done_phase = cfg_seq_pkg::DONE_PHASE_DEF;
    cfg.float_phase = cfg_seq_pkg::FLOAT_PHASE_DEF;
    cfg.write_phase = cfg_seq_pkg::WRITE_PHASE_DEF;
    cfg.lock_wait_en = 1'b1;
    locked = 4'h0;
    program_pulse();
    cyc(300);
    chk({3'h0, done_oe}, 4'h1);
    locked = 4'h3;
    cyc(20);
    chk({3'h0, done_oe}, 4'h1);
    mask = 4'h3;
    wait_done();
    chk({3'h0, done_oe}, 4'h0);
    cfg.lock_wait_en = 1'b0;
    cfg.float_wait_done = 1'b1;
    cfg.write_wait_done = 1'b1;
    done_hold = 1'b1;
    program_pulse();
    cyc(300);
    chk({1'b0, done_oe, gc.global_output_float, gc.global_write_enable}, 4'h2);
    done_hold = 1'b0;
    cyc(8);
    chk({1'b0, done_oe, gc.global_output_float, gc.global_write_enable}, 4'h1);
    {app_sr, app_fl, app_cap} = 3'h7;
    cyc(3);
    chk({1'b0, gc.global_set_reset, gc.global_output_float, cap_st}, 4'h7);
    {app_sr, app_fl, app_cap} = 3'h0;
    cyc(3);
    chk({1'b0, gc.global_set_reset, gc.global_output_float, cap_st}, 4'h0);
    rb_req = 1'b1;
    for (k = 0; k < 4; k++) begin
      rb_port = 2'(k);
      cyc(3);
      chk({3'h0, rb_en}, {3'h0, k == 1 || k == 2});
    end
    rb_port = cfg_seq_pkg::READBACK_PORT_PARALLEL;
    for (k = 1; k < 3; k++) begin
      cfg.security_level = 2'(k);
      cyc(3);
      chk({3'h0, rb_en}, 4'h0);
    end
    // A CRC error in mid-load must block completion.
    cfg.security_level = cfg_seq_pkg::SECURITY_NONE;
    load_done = 1'b0;
    program_pulse();
    cyc(20);
    crc_err = 1'b1;
    cyc(1);
    crc_err = 1'b0;
    load_done = 1'b1;
    cyc(200);
    chk({2'h0, init_oe, done_oe}, 4'h3);
    finish_test();
  end
endmodule
